// *** bench/ext_pin_model.sv ***
module ext_pin_model (
   // clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // pattern selection: 0 low, 1 high, 2 square wave
   input wire logic [1:0] mode_lo,
   input wire logic [1:0] mode_hi,
   input wire logic [7:0] half,
   // pins
   output logic pin_lo,
   output logic pin_hi
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] cnt;
   logic wave;

   // square wave of period 2*half cycles, one rising edge per period
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cnt <= 8'h00;
         wave <= 1'b0;
      end else if (cnt >= half - 8'h01) begin
         cnt <= 8'h00;
         wave <= ~wave;
      end else begin
         cnt <= cnt + 8'h01;
      end
   end

   // held levels stand for a gate, the wave for an external clock
   assign pin_lo = (mode_lo == 2'd2) ? wave : mode_lo[0];
   assign pin_hi = (mode_hi == 2'd2) ? wave : mode_hi[0];
endmodule : ext_pin_model

// *** bench/paired_timer_16_32_tb.sv ***
module paired_timer_16_32_tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, irq, idle_mode, pin_lo, pin_hi;
   logic [31:0] haddr, hwdata, hrdata, rng, rd, a, b;
   logic [1:0] htrans, mode_lo, mode_hi;
   logic [2:0] hsize;
   logic [7:0] half;
   int fail_count, checks, cycles;
   int ratio[4] = '{1, 8, 64, 256};

   paired_timer_16_32 dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .low_word_ext_clock_pin(pin_lo),
      .high_word_ext_clock_pin(pin_hi), .idle_mode(idle_mode), .irq(irq));

   ext_pin_model pins (.hclk(hclk), .hresetn(hresetn), .mode_lo(mode_lo), .mode_hi(mode_hi),
      .half(half), .pin_lo(pin_lo), .pin_hi(pin_hi));

   initial begin
      hclk = 1'b0;
      forever #50 hclk = ~hclk;
   end

   function automatic logic [31:0] xorshift(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      x = x ^ (x << 5);
      return x;
   endfunction : xorshift

   function automatic logic [31:0] ctrl_word(input logic run, input logic halt,
      input logic gate, input logic [1:0] ps, input logic pair, input logic cs);
      return {16'h0000, run, 1'b0, halt, 6'h00, gate, ps, pair, 1'b0, cs, 1'b0};
   endfunction : ctrl_word

   // writable control positions; the join bit exists only in the low word
   function automatic logic [15:0] ctrl_mask(input logic is_low);
      return {1'b1, 1'b0, 1'b1, 6'h00, 1'b1, 2'b11, is_low, 1'b0, 1'b1, 1'b0};
   endfunction : ctrl_mask

   task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task final_report;
      $display("checks %0d mismatches %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : final_report

   // one single transfer; entered and left just after a rising edge
   task bus(input logic wr, input logic [7:0] addr, input logic [31:0] wd,
      output logic [31:0] rdv);
      hsel <= 1'b1;
      htrans <= 2'b10;
      haddr <= {24'h0000_00, addr};
      hwrite <= wr;
      hsize <= 3'b010;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      htrans <= 2'b00;
      hsel <= 1'b0;
      hwdata <= wd;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rdv = hrdata;
   endtask : bus

   task wr(input logic [7:0] addr, input logic [31:0] d);
      bus(1'b1, addr, d, rd);
   endtask : wr

   task rdchk(input string what, input logic [7:0] addr, input logic [31:0] exp);
      bus(1'b0, addr, 32'h0000_0000, rd);
      check(what, rd, exp);
      check("response", {31'h0, hresp}, 32'h0000_0000);
   endtask : rdchk

   // two count reads exactly d cycles apart
   task delta(input logic [7:0] addr, input int d, input logic [31:0] exp);
      bus(1'b0, addr, 32'h0000_0000, a);
      repeat (d - 3) @(posedge hclk);
      bus(1'b0, addr, 32'h0000_0000, b);
      check("count delta", {16'h0000, b[15:0] - a[15:0]}, exp);
   endtask : delta

   always @(posedge hclk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         fail_count++;
         final_report();
      end
   end

   initial begin
      hresetn = 1'b0;
      hsel = 1'b0;
      htrans = 2'b00;
      haddr = 32'h0000_0000;
      hwrite = 1'b0;
      hsize = 3'b010;
      hwdata = 32'h0000_0000;
      idle_mode = 1'b0;
      mode_lo = 2'd0;
      mode_hi = 2'd0;
      half = 8'h04;
      rng = 32'hb62a_6e3b;
      fail_count = 0;
      checks = 0;
      cycles = 0;
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      for (int i = 0; i < 9; i++) begin
         rdchk("reset value", 8'(i * 4),
            (i == 4 || i == 5) ? 32'h0000_ffff : 32'h0000_0000);
      end
      for (int i = 0; i < 6; i++) begin
         rng = xorshift(rng);
         wr(8'h00, rng);
         rdchk("low ctrl", 8'h00, {16'h0000, rng[15:0] & ctrl_mask(1'b1)});
         wr(8'h04, {rng[15:0], rng[31:16]});
         rdchk("high ctrl", 8'h04, {16'h0000, rng[31:16] & ctrl_mask(1'b0)});
         wr(8'h14, rng);
         rdchk("high period", 8'h14, {16'h0000, rng[15:0]});
      end
      wr(8'h20, rng);
      rdchk("unmapped", 8'h20, 32'h0000_0000);
      wr(8'h00, 32'h0000_0000);
      wr(8'h04, 32'h0000_0000);
      wr(8'h10, 32'h0000_ffff);
      wr(8'h14, 32'h0000_ffff);
      for (int i = 0; i < 4; i++) begin
         wr(8'h00, ctrl_word(1'b1, 1'b0, 1'b0, 2'(i), 1'b0, 1'b0));
         delta(8'h08, 512, 32'(512 / ratio[i]));
      end
      wr(8'h00, 32'h0000_0000);
      delta(8'h08, 64, 32'h0000_0000);
      for (int i = 0; i < 4; i++) begin
         idle_mode <= i[1];
         wr(8'h00, ctrl_word(1'b1, i[0], 1'b0, 2'b00, 1'b0, 1'b0));
         delta(8'h08, 64, (i == 3) ? 32'h0000_0000 : 32'h0000_0040);
      end
      idle_mode <= 1'b0;
      wr(8'h18, 32'h0000_0003);
      mode_lo <= 2'd1;
      wr(8'h00, ctrl_word(1'b1, 1'b0, 1'b1, 2'b00, 1'b0, 1'b0));
      repeat (4) @(posedge hclk);
      delta(8'h08, 64, 32'h0000_0040);
      mode_lo <= 2'd0;
      repeat (4) @(posedge hclk);
      delta(8'h08, 64, 32'h0000_0000);
      rdchk("gate fall flag", 8'h18, 32'h0000_0001);
      mode_lo <= 2'd2;
      wr(8'h00, ctrl_word(1'b1, 1'b0, 1'b1, 2'b00, 1'b0, 1'b1));
      delta(8'h08, 64, 32'h0000_0008);
      wr(8'h00, 32'h0000_0000);
      mode_lo <= 2'd0;
      mode_hi <= 2'd2;
      wr(8'h04, ctrl_word(1'b1, 1'b0, 1'b0, 2'b00, 1'b0, 1'b1));
      delta(8'h0c, 64, 32'h0000_0008);
      wr(8'h04, ctrl_word(1'b1, 1'b0, 1'b0, 2'b01, 1'b0, 1'b0));
      delta(8'h0c, 64, 32'h0000_0008);
      mode_hi <= 2'd0;
      for (int j = 0; j < 2; j++) begin
         wr(8'h00, 32'h0000_0000);
         wr(8'h08, 32'h0000_ff00);
         // park the high lane on a quiet pin before clearing its count
         wr(8'h04, ctrl_word(1'b1, 1'b0, 1'b1, 2'b11, 1'b0, 1'b1));
         wr(8'h0c, 32'h0000_0000);
         wr(8'h00, ctrl_word(1'b1, 1'b0, 1'b0, 2'b00, j[0], 1'b0));
         repeat (300) @(posedge hclk);
         wr(8'h00, 32'h0000_0000);
         rdchk("high count", 8'h0c, 32'(j));
      end
      wr(8'h04, 32'h0000_0000);
      for (int j = 0; j < 2; j++) begin
         wr(8'h18, 32'h0000_0003);
         wr(8'h08, 32'h0000_0000);
         wr(8'h0c, 32'h0000_0000);
         wr(8'h10, 32'h0000_0014);
         wr(8'h14, 32'h0000_0000);
         wr(8'h1c, 32'h0000_0003);
         wr(8'h00, ctrl_word(1'b1, 1'b0, 1'b0, 2'b00, j[0], 1'b0));
         repeat (30) @(posedge hclk);
         wr(8'h00, 32'h0000_0000);
         bus(1'b0, 8'h08, 32'h0000_0000, rd);
         check("count in period", {31'h0, rd <= 32'h0000_0014}, 32'h0000_0001);
         rdchk("status", 8'h18, j ? 32'h0000_0002 : 32'h0000_0001);
         check("irq on", {31'h0, irq}, 32'h0000_0001);
         wr(8'h1c, 32'h0000_0000);
         @(posedge hclk);
         check("irq masked", {31'h0, irq}, 32'h0000_0000);
         wr(8'h18, 32'h0000_0003);
         rdchk("status clear", 8'h18, 32'h0000_0000);
      end
      final_report();
   end
endmodule : paired_timer_16_32_tb

// *** core/paired_timer_16_32.sv ***
module paired_timer_16_32 (
   // clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // ahb-lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   // timer pins and power state
   input wire logic low_word_ext_clock_pin,
   input wire logic high_word_ext_clock_pin,
   input wire logic idle_mode,
   // interrupt
   output logic irq
);

   paired_timer_pkg::core_state_t st_reg;
   paired_timer_pkg::core_state_t st_next;
   paired_timer_pkg::lane_ctrl_t ctl_lo;
   paired_timer_pkg::lane_ctrl_t ctl_hi;
   logic pair;
   logic tick_lo;
   logic tick_hi;
   logic fall_lo;
   logic fall_hi;
   logic [1:0] ev;
   logic [1:0] w1c;
   logic [16:0] step_lo;
   logic [16:0] step_hi;

   // returns {period hit, next count}
   function automatic logic [16:0] bump16(input logic [15:0] c, input logic [15:0] p);
      logic [16:0] r;
      if (c == p) begin
         r = {1'b1, 16'h0000};
      end else begin
         r = {1'b0, 16'(c + 16'h0001)};
      end
      return r;
   endfunction : bump16

   assign pair = st_reg.ctrl_lo[paired_timer_pkg::BIT_PAIR];
   assign ctl_lo = paired_timer_pkg::decode_ctrl(st_reg.ctrl_lo);
   // high control is silenced while joined
   assign ctl_hi = pair ? '0 : paired_timer_pkg::decode_ctrl(st_reg.ctrl_hi);

   timer_lane u_low (
      .hclk(hclk),
      .hresetn(hresetn),
      .ctrl(ctl_lo),
      .idle_mode(idle_mode),
      .ext_pin(low_word_ext_clock_pin),
      .tick(tick_lo),
      .gate_fall(fall_lo)
   );

   timer_lane u_high (
      .hclk(hclk),
      .hresetn(hresetn),
      .ctrl(ctl_hi),
      .idle_mode(idle_mode),
      .ext_pin(high_word_ext_clock_pin),
      .tick(tick_hi),
      .gate_fall(fall_hi)
   );

   assign hreadyout = !(st_reg.dp_valid && !st_reg.dp_write && !st_reg.rd_ready);
   assign hresp = 1'b0;
   assign hrdata = st_reg.rdata;
   assign irq = |(st_reg.status & st_reg.mask);

   always_comb begin
      st_next = st_reg;
      ev = 2'b00;
      w1c = 2'b00;
      step_lo = bump16(st_reg.cnt_lo, st_reg.per_lo);
      step_hi = bump16(st_reg.cnt_hi, st_reg.per_hi);

      // counting
      if (pair) begin
         if (tick_lo) begin
            if ({st_reg.cnt_hi, st_reg.cnt_lo} == {st_reg.per_hi, st_reg.per_lo}) begin
               st_next.cnt_hi = 16'h0000;
               st_next.cnt_lo = 16'h0000;
               ev[paired_timer_pkg::IRQ_HIGH] = 1'b1;
            end else begin
               // low word is the lsw, high word the msw
               {st_next.cnt_hi, st_next.cnt_lo} =
                  32'({st_reg.cnt_hi, st_reg.cnt_lo} + 32'h0000_0001);
            end
         end
         if (fall_lo) begin
            ev[paired_timer_pkg::IRQ_HIGH] = 1'b1;
         end
      end else begin
         if (tick_lo) begin
            st_next.cnt_lo = step_lo[15:0];
            ev[paired_timer_pkg::IRQ_LOW] = step_lo[16];
         end
         if (tick_hi) begin
            st_next.cnt_hi = step_hi[15:0];
            ev[paired_timer_pkg::IRQ_HIGH] = step_hi[16];
         end
         if (fall_lo) begin
            ev[paired_timer_pkg::IRQ_LOW] = 1'b1;
         end
         if (fall_hi) begin
            ev[paired_timer_pkg::IRQ_HIGH] = 1'b1;
         end
      end

      // bus write data phase, software write overrides counting
      if (st_reg.dp_valid && st_reg.dp_write) begin
         case (st_reg.dp_addr)
            paired_timer_pkg::OFF_LOW_CTRL: begin
               st_next.ctrl_lo = hwdata[15:0] & paired_timer_pkg::LOW_CTRL_MASK;
            end
            paired_timer_pkg::OFF_HIGH_CTRL: begin
               st_next.ctrl_hi = hwdata[15:0] & paired_timer_pkg::HIGH_CTRL_MASK;
            end
            paired_timer_pkg::OFF_LOW_COUNT: begin
               st_next.cnt_lo = hwdata[15:0];
            end
            paired_timer_pkg::OFF_HIGH_COUNT: begin
               st_next.cnt_hi = hwdata[15:0];
            end
            paired_timer_pkg::OFF_LOW_PERIOD: begin
               st_next.per_lo = hwdata[15:0];
            end
            paired_timer_pkg::OFF_HIGH_PERIOD: begin
               st_next.per_hi = hwdata[15:0];
            end
            paired_timer_pkg::OFF_IRQ_STATUS: begin
               w1c = hwdata[1:0];
            end
            paired_timer_pkg::OFF_IRQ_MASK: begin
               st_next.mask = hwdata[1:0];
            end
            default: begin
            end
         endcase
      end
      // a new event beats a clear in the same cycle
      st_next.status = (st_reg.status & ~w1c) | ev;

      // read data phase: one wait state, then registered data
      if (st_reg.dp_valid && !st_reg.dp_write && !st_reg.rd_ready) begin
         st_next.rd_ready = 1'b1;
         case (st_reg.dp_addr)
            paired_timer_pkg::OFF_LOW_CTRL: st_next.rdata = {16'h0000, st_reg.ctrl_lo};
            paired_timer_pkg::OFF_HIGH_CTRL: st_next.rdata = {16'h0000, st_reg.ctrl_hi};
            paired_timer_pkg::OFF_LOW_COUNT: st_next.rdata = {16'h0000, st_reg.cnt_lo};
            paired_timer_pkg::OFF_HIGH_COUNT: st_next.rdata = {16'h0000, st_reg.cnt_hi};
            paired_timer_pkg::OFF_LOW_PERIOD: st_next.rdata = {16'h0000, st_reg.per_lo};
            paired_timer_pkg::OFF_HIGH_PERIOD: st_next.rdata = {16'h0000, st_reg.per_hi};
            paired_timer_pkg::OFF_IRQ_STATUS: st_next.rdata = {30'h0000_0000, st_reg.status};
            paired_timer_pkg::OFF_IRQ_MASK: st_next.rdata = {30'h0000_0000, st_reg.mask};
            default: st_next.rdata = 32'h0000_0000;
         endcase
      end

      // address phase
      if (hready) begin
         st_next.dp_valid = hsel && htrans[1];
         st_next.dp_write = hwrite;
         st_next.dp_addr = haddr[7:0];
         st_next.rd_ready = 1'b0;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         st_reg <= '{
            ctrl_lo: paired_timer_pkg::CTRL_RESET,
            ctrl_hi: paired_timer_pkg::CTRL_RESET,
            cnt_lo: paired_timer_pkg::COUNT_RESET,
            cnt_hi: paired_timer_pkg::COUNT_RESET,
            per_lo: paired_timer_pkg::PERIOD_RESET,
            per_hi: paired_timer_pkg::PERIOD_RESET,
            status: paired_timer_pkg::IRQ_RESET,
            mask: paired_timer_pkg::IRQ_RESET,
            default: '0
         };
      end else begin
         st_reg <= st_next;
      end
   end

   // helper terms for the checks below
   logic wr_any;
   logic wr_cnt_lo;
   logic wr_cnt_hi;
   assign wr_any = st_reg.dp_valid && st_reg.dp_write;
   assign wr_cnt_lo = wr_any && st_reg.dp_addr == paired_timer_pkg::OFF_LOW_COUNT;
   assign wr_cnt_hi = wr_any && st_reg.dp_addr == paired_timer_pkg::OFF_HIGH_COUNT;

   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);

   low_ctrl_unimpl_a: assert property (
      (st_reg.ctrl_lo & ~paired_timer_pkg::LOW_CTRL_MASK) == 16'h0000)
      else $error("unimplemented low control bit set");

   high_ctrl_unimpl_a: assert property (
      (st_reg.ctrl_hi & ~paired_timer_pkg::HIGH_CTRL_MASK) == 16'h0000)
      else $error("unimplemented high control bit set");

   low_run_off_a: assert property (
      !st_reg.ctrl_lo[paired_timer_pkg::BIT_RUN] && !wr_cnt_lo |=> $stable(st_reg.cnt_lo))
      else $error("low count moved while stopped");

   idle_halt_a: assert property (
      idle_mode && st_reg.ctrl_lo[paired_timer_pkg::BIT_HALT_IDLE] && !wr_cnt_lo
      |=> $stable(st_reg.cnt_lo))
      else $error("low count moved while halted in idle");

   pair_wrap_a: assert property (
      pair && tick_lo && !wr_any
      && {st_reg.cnt_hi, st_reg.cnt_lo} == {st_reg.per_hi, st_reg.per_lo}
      |=> st_reg.cnt_lo == 16'h0000 && st_reg.cnt_hi == 16'h0000
      && st_reg.status[paired_timer_pkg::IRQ_HIGH])
      else $error("paired count did not wrap and flag high");

   pair_high_follow_a: assert property (
      pair && !tick_lo && !wr_cnt_hi |=> $stable(st_reg.cnt_hi))
      else $error("high word moved without a low tick in joined mode");

   pair_carry_a: assert property (
      pair && tick_lo && !wr_any && st_reg.cnt_lo == 16'hFFFF
      && {st_reg.cnt_hi, st_reg.cnt_lo} != {st_reg.per_hi, st_reg.per_lo}
      |=> st_reg.cnt_lo == 16'h0000 && st_reg.cnt_hi == $past(st_reg.cnt_hi) + 16'h0001)
      else $error("low word overflow did not carry into high word");

   gate_fall_flag_a: assert property (
      !pair && fall_lo |=> st_reg.status[paired_timer_pkg::IRQ_LOW])
      else $error("gate falling edge did not set the low flag");

   irq_level_a: assert property (
      |(ev & st_reg.mask) && !wr_any |=> irq)
      else $error("unmasked event did not raise the interrupt");

   high_run_off_a: assert property (
      !pair && !st_reg.ctrl_hi[paired_timer_pkg::BIT_RUN] && !wr_cnt_hi
      |=> $stable(st_reg.cnt_hi))
      else $error("high count moved while stopped");

   high_idle_halt_a: assert property (
      !pair && idle_mode && st_reg.ctrl_hi[paired_timer_pkg::BIT_HALT_IDLE] && !wr_cnt_hi
      |=> $stable(st_reg.cnt_hi))
      else $error("high count moved while halted in idle");

   high_lane_quiet_a: assert property (
      pair |-> !tick_hi && !fall_hi)
      else $error("high lane active while joined");

   split_low_wrap_a: assert property (
      !pair && tick_lo && !wr_any && st_reg.cnt_lo == st_reg.per_lo
      |=> st_reg.cnt_lo == 16'h0000 && st_reg.status[paired_timer_pkg::IRQ_LOW])
      else $error("low count did not wrap and flag at its period");

   low_step_a: assert property (
      !pair && tick_lo && !wr_cnt_lo && st_reg.cnt_lo != st_reg.per_lo
      |=> st_reg.cnt_lo == $past(st_reg.cnt_lo) + 16'h0001)
      else $error("low count did not step by one on a tick");

   high_step_a: assert property (
      !pair && tick_hi && !wr_cnt_hi && st_reg.cnt_hi != st_reg.per_hi
      |=> st_reg.cnt_hi == $past(st_reg.cnt_hi) + 16'h0001)
      else $error("high count did not step by one on a tick");

   // every register is at most a half word, so the upper read half stays zero
   read_upper_zero_a: assert property (
      st_reg.dp_valid && !st_reg.dp_write && st_reg.rd_ready |-> hrdata[31:16] == 16'h0000)
      else $error("read data above bit 15 not zero");

   // a read waits exactly one cycle so that read data comes from a flop
   read_wait_a: assert property (
      hready && hsel && htrans[1] && !hwrite |=> !hreadyout ##1 hreadyout)
      else $error("read wait state not exactly one cycle");

   status_sticky_a: assert property (
      !wr_any |=> (st_reg.status & $past(st_reg.status)) == $past(st_reg.status))
      else $error("status bit dropped without a clear");

   pair_wrap_c: cover property (pair && tick_lo && st_reg.cnt_lo == st_reg.per_lo
      && st_reg.cnt_hi == st_reg.per_hi);
   gate_fall_c: cover property (fall_lo);
   idle_halt_c: cover property (idle_mode && st_reg.ctrl_lo[paired_timer_pkg::BIT_HALT_IDLE]
      && st_reg.ctrl_lo[paired_timer_pkg::BIT_RUN]);
   split_both_c: cover property (!pair && tick_lo && tick_hi);
   split_wrap_c: cover property (!pair && tick_lo && st_reg.cnt_lo == st_reg.per_lo);

endmodule : paired_timer_16_32

// *** core/paired_timer_pkg.sv ***
// Overview of operation
// - low run bit starts/stops the low timer, or the whole 32-bit pair when joined
// - high run bit starts/stops the separate 16-bit high timer when not joined
// - halt_in_idle set stops the timer while idle; clear keeps it counting
// - gate accumulation works only with internal clock; ignored with external clock
// - prescale_select divides the source: 11=256, 10=64, 01=8, 00=1
// - pair_join_select joins both timers into one 32-bit timer
// - clock_source_select set counts external pin rising edges, clear counts internal clock
// - while joined, high control run, gate, prescale and source bits do nothing
// - unimplemented control bits always read as zero
// - joined: low timer holds count bits 15..0, high timer bits 31..16
// - joined: low timer clock and gate used, high timer flag raised
package paired_timer_pkg;

   // register byte offsets
   localparam logic [7:0] OFF_LOW_CTRL = 8'h00;
   localparam logic [7:0] OFF_HIGH_CTRL = 8'h04;
   localparam logic [7:0] OFF_LOW_COUNT = 8'h08;
   localparam logic [7:0] OFF_HIGH_COUNT = 8'h0C;
   localparam logic [7:0] OFF_LOW_PERIOD = 8'h10;
   localparam logic [7:0] OFF_HIGH_PERIOD = 8'h14;
   localparam logic [7:0] OFF_IRQ_STATUS = 8'h18;
   localparam logic [7:0] OFF_IRQ_MASK = 8'h1C;

   // control field positions
   localparam int BIT_RUN = 15;
   localparam int BIT_HALT_IDLE = 13;
   localparam int BIT_GATE = 6;
   localparam int BIT_PS_HI = 5;
   localparam int BIT_PS_LO = 4;
   localparam int BIT_PAIR = 3;
   localparam int BIT_CLK_SRC = 1;

   // implemented control bits
   localparam logic [15:0] LOW_CTRL_MASK = 16'hA07A;
   localparam logic [15:0] HIGH_CTRL_MASK = 16'hA072;

   // reset values
   localparam logic [15:0] CTRL_RESET = 16'h0000;
   localparam logic [15:0] COUNT_RESET = 16'h0000;
   localparam logic [15:0] PERIOD_RESET = 16'hFFFF;
   localparam logic [1:0] IRQ_RESET = 2'b00;

   // interrupt bit positions
   localparam int IRQ_LOW = 0;
   localparam int IRQ_HIGH = 1;

   // prescaler terminal counts (ratio minus one)
   localparam logic [7:0] PS_LIM_1 = 8'h00;
   localparam logic [7:0] PS_LIM_8 = 8'h07;
   localparam logic [7:0] PS_LIM_64 = 8'h3F;
   localparam logic [7:0] PS_LIM_256 = 8'hFF;

   typedef struct packed {
      logic run;
      logic halt;
      logic gate;
      logic [1:0] ps;
      logic cs;
   } lane_ctrl_t;

   typedef struct packed {
      logic [7:0] ps_cnt;
      logic pin_prev;
   } lane_state_t;

   typedef struct packed {
      logic [15:0] ctrl_lo;
      logic [15:0] ctrl_hi;
      logic [15:0] cnt_lo;
      logic [15:0] cnt_hi;
      logic [15:0] per_lo;
      logic [15:0] per_hi;
      logic [1:0] status;
      logic [1:0] mask;
      logic dp_valid;
      logic dp_write;
      logic [7:0] dp_addr;
      logic rd_ready;
      logic [31:0] rdata;
   } core_state_t;

   function automatic lane_ctrl_t decode_ctrl(input logic [15:0] r);
      lane_ctrl_t c;
      c.run = r[BIT_RUN];
      c.halt = r[BIT_HALT_IDLE];
      c.gate = r[BIT_GATE];
      c.ps = r[BIT_PS_HI:BIT_PS_LO];
      c.cs = r[BIT_CLK_SRC];
      return c;
   endfunction : decode_ctrl

   function automatic logic [7:0] prescale_limit(input logic [1:0] sel);
      logic [7:0] l;
      case (sel)
         2'b11: l = PS_LIM_256;
         2'b10: l = PS_LIM_64;
         2'b01: l = PS_LIM_8;
         default: l = PS_LIM_1;
      endcase
      return l;
   endfunction : prescale_limit

endpackage : paired_timer_pkg

// *** core/timer_lane.sv ***
module timer_lane (
   // clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // control
   input wire paired_timer_pkg::lane_ctrl_t ctrl,
   input wire logic idle_mode,
   input wire logic ext_pin,
   // events
   output logic tick,
   output logic gate_fall
);

   paired_timer_pkg::lane_state_t st_reg;
   paired_timer_pkg::lane_state_t st_next;
   logic en;
   logic gated;
   logic src_ev;
   logic [7:0] lim;

   always_comb begin
      st_next = st_reg;
      en = ctrl.run && !(ctrl.halt && idle_mode);
      gated = ctrl.gate && !ctrl.cs;
      lim = paired_timer_pkg::prescale_limit(ctrl.ps);
      if (ctrl.cs) begin
         src_ev = ext_pin && !st_reg.pin_prev;
      end else begin
         src_ev = !gated || ext_pin;
      end
      tick = en && src_ev && (st_reg.ps_cnt >= lim);
      gate_fall = en && gated && st_reg.pin_prev && !ext_pin;
      st_next.pin_prev = ext_pin;
      if (!en) begin
         st_next.ps_cnt = 8'h00;
      end else if (src_ev) begin
         st_next.ps_cnt = tick ? 8'h00 : 8'(st_reg.ps_cnt + 8'h01);
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);

   prescale_by_eight_a: assert property (
      tick && !ctrl.cs && !ctrl.gate && ctrl.ps == 2'b01 && !idle_mode
      // software may switch to divide by one meanwhile; those ticks are not ours
      |=> (!tick || ctrl.ps != 2'b01) [*7])
      else $error("tick closer than eight cycles at divide by eight");

   ext_rising_edge_a: assert property (
      tick && ctrl.cs |-> ext_pin && !$past(ext_pin))
      else $error("external tick without a rising pin edge");

   gate_low_blocks_a: assert property (
      !ctrl.cs && ctrl.gate && !ext_pin |-> !tick)
      else $error("gated tick while gate low");

endmodule : timer_lane
